// ===== rcb_consts.svh
// Purpose: constants of the reset configuration and boot vector block
// Assumes: included by its bare name from the package only; the top module uses its macros
// Notes: positions refer to the data bus slice D[31:16] as seen at reset
`ifndef RCB_CONSTS_SVH
`define RCB_CONSTS_SVH

// -------------------------------------------------------------
// status word layout and reset values
// -------------------------------------------------------------
`define RCB_SR_TRACE_BIT 15
`define RCB_SR_SUPER_BIT 13
`define RCB_SR_MASTER_BIT 12
`define RCB_SR_MASK_LSB 8
`define RCB_SR_RESET 16'h2700
`define RCB_VBR_RESET 32'h0000_0000
`define RCB_SP_ADDR 32'h0000_0000
`define RCB_PC_ADDR 32'h0000_0004

// -------------------------------------------------------------
// configuration bit positions within D[31:16]
// -------------------------------------------------------------
`define RCB_POS_CLK_LO 0
`define RCB_POS_BOOTW_LO 3
`define RCB_POS_CHIP_LO 5
`define RCB_POS_BOOTD_LO 8
`define RCB_POS_DRIVE 10
`define RCB_POS_ADDR_LO 11

// -------------------------------------------------------------
// chip select geometry
// -------------------------------------------------------------
`define RCB_CS_COUNT 8
`define RCB_CS_GRAN_LSB 16
`define RCB_CS_BASE_RESET 16'h0000
`define RCB_CS_MASK_RESET 16'h0000

`endif

// ===== rcb_pkg.sv
// Purpose: types of the reset configuration and boot vector block
// Assumes: rcb_consts.svh holds every number
// Notes: switch on is read as logic one on the sampled pin
`default_nettype none
package rcb_pkg;
  `include "rcb_consts.svh"

  // -------------------------------------------------------------
  // configuration fields
  // -------------------------------------------------------------
  typedef enum logic [1:0] {RCB_CLK_PLL, RCB_CLK_EXT, RCB_CLK_ONE} rcb_clk_mode_t;
  typedef enum logic [1:0] {RCB_PS_16, RCB_PS_8, RCB_PS_RSVD} rcb_port_size_t;
  typedef enum logic {RCB_CHIP_MASTER, RCB_CHIP_RSVD} rcb_chip_mode_t;
  typedef enum logic [1:0] {RCB_BOOT_16, RCB_BOOT_8, RCB_BOOT_RSVD} rcb_boot_dev_t;
  typedef enum logic {RCB_DRV_FULL, RCB_DRV_PART} rcb_drive_t;
  typedef enum logic [1:0] {RCB_PA_A23_21, RCB_PA_CS6_A22, RCB_PA_CS65_A21, RCB_PA_CS6_4} rcb_addr_mode_t;
  typedef enum logic {RCB_DBG_SCAN, RCB_DBG_BDM} rcb_dbg_port_t;

  // chip settings travelling together
  typedef struct packed {
    rcb_clk_mode_t clk_mode;
    rcb_port_size_t port_size;
    rcb_chip_mode_t chip_mode;
    rcb_boot_dev_t boot_dev;
    rcb_drive_t drive;
    rcb_addr_mode_t addr_mode;
  } rcb_cfg_t;

  // one chip select programming write
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [15:0] base;
    logic [15:0] mask;
    logic valid;
  } rcb_cs_wr_t;

  // boot sequencer states
  typedef enum logic [2:0] {RCB_ST_WAIT_GNT, RCB_ST_RD_SP, RCB_ST_RD_PC, RCB_ST_FETCH,
                            RCB_ST_RUN, RCB_ST_HALT} rcb_state_t;
endpackage
`default_nettype wire

// ===== rcb_reset_boot.sv
// Purpose: reset state, reset-time configuration capture and boot vector fetch
// Assumes: single 40 MHz clock, sys_rst held at least five edges
// Notes: pins pass a three-flop synchroniser before capture
`timescale 1ns/10ps
`default_nettype none
module rcb_reset_boot (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_config_select_n,
  input wire logic debug_select_pin,
  input wire logic [15:0] data_pins_in,
  input wire logic int_cfg_use,
  input wire rcb_pkg::rcb_cfg_t int_cfg,
  input wire logic bus_grant,
  output logic bus_req,
  output logic rd_valid,
  output logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  input wire rcb_pkg::rcb_cs_wr_t cs_wr,
  output logic boot_chip_select_n,
  output logic [6:0] ext_chip_select_n,
  output rcb_pkg::rcb_cfg_t chip_cfg,
  output rcb_pkg::rcb_dbg_port_t debug_port,
  output logic [15:0] core_status_word,
  output logic [31:0] vector_base,
  output logic cache_enable,
  output logic local_ram_enable,
  output logic [31:0] stack_ptr,
  output logic [31:0] prog_ctr,
  output logic core_running,
  output logic core_halted
);
  import rcb_pkg::*;

  // -------------------------------------------------------------
  // functions
  // -------------------------------------------------------------
  // bank match on 64-KByte granules; set mask bits are don't-care
  function automatic logic cs_hit(input logic [31:0] a, input logic [15:0] b, input logic [15:0] m);
    cs_hit = ((a[31:`RCB_CS_GRAN_LSB] ^ b) & ~m) == 16'h0000;
  endfunction

  // switch pair to two-bit code, first switch in the high bit
  function automatic logic [1:0] pair(input logic [15:0] d, input int lo);
    pair = {d[lo], d[lo+1]};
  endfunction

  // -------------------------------------------------------------
  // pin synchroniser
  // -------------------------------------------------------------
  // the switches and data pins are asynchronous to clk; three
  // flops per bit keep metastability away from the decode, and a
  // level counts only once stages two and three agree
  // trade-off: the agreement filter adds one more cycle of delay,
  // which is why reset must stand for at least five edges
  // the agreed levels are only captured while reset is high
  logic [16:0] sync1_r; // first stage, read only by second
  logic [16:0] sync2_r; // second stage
  logic [16:0] sync3_r; // third stage
  logic [16:0] pin_flt_r; // agreed pin levels
  wire [16:0] pin_raw = {debug_select_pin, data_pins_in};
  wire [16:0] pin_agree = ~(sync2_r ^ sync3_r); // per bit agreement
  wire [16:0] pin_flt_nxt = (pin_agree & sync2_r) | (~pin_agree & pin_flt_r);
  logic rsel_s1_r; // select pin, first stage
  logic rsel_s2_r;
  logic rsel_s3_r;
  logic rsel_flt_r; // agreed select level, active high

  // sync flops run through reset so the levels are there at release
  always_ff @(posedge clk) begin
    sync1_r <= pin_raw;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    pin_flt_r <= pin_flt_nxt;
    rsel_s1_r <= ~reset_config_select_n;
    rsel_s2_r <= rsel_s1_r;
    rsel_s3_r <= rsel_s2_r;
    if (rsel_s2_r == rsel_s3_r) begin
      rsel_flt_r <= rsel_s2_r;
    end
  end

  // -------------------------------------------------------------
  // pin configuration decode
  // -------------------------------------------------------------
  wire [15:0] dp = pin_flt_r[15:0];
  wire [1:0] clk_code = pair(dp, `RCB_POS_CLK_LO);
  wire [1:0] bootw_code = {dp[`RCB_POS_BOOTW_LO+1], dp[`RCB_POS_BOOTW_LO]}; // D20, D19
  wire [1:0] bootd_code = pair(dp, `RCB_POS_BOOTD_LO);
  wire [1:0] addr_code = pair(dp, `RCB_POS_ADDR_LO);
  wire chip_all_on = &dp[`RCB_POS_CHIP_LO+2:`RCB_POS_CHIP_LO];
  // both on or first on alone is pll; the external reference case
  wire rcb_clk_mode_t clk_dec = clk_code[1] ? RCB_CLK_PLL : (clk_code[0] ? RCB_CLK_EXT : RCB_CLK_ONE);
  wire rcb_port_size_t ps_dec = (bootw_code == 2'h1) ? RCB_PS_16 :
                                (bootw_code == 2'h2) ? RCB_PS_8 : RCB_PS_RSVD;
  wire rcb_chip_mode_t chip_dec = chip_all_on ? RCB_CHIP_MASTER : RCB_CHIP_RSVD;
  wire rcb_boot_dev_t bootd_dec = (bootd_code == 2'h3) ? RCB_BOOT_16 :
                                  (bootd_code == 2'h0) ? RCB_BOOT_8 : RCB_BOOT_RSVD;
  wire rcb_drive_t drv_dec = dp[`RCB_POS_DRIVE] ? RCB_DRV_FULL : RCB_DRV_PART;
  // on/on all address, on/off cs6, off/on cs6-5, off/off cs6-4
  wire rcb_addr_mode_t addr_dec = rcb_addr_mode_t'(~addr_code);
  wire rcb_cfg_t pin_cfg = '{clk_mode: clk_dec, port_size: ps_dec, chip_mode: chip_dec,
                             boot_dev: bootd_dec, drive: drv_dec, addr_mode: addr_dec};
  // fixed defaults when neither pins nor the internal register apply
  wire rcb_cfg_t dflt_cfg = '{clk_mode: RCB_CLK_PLL, port_size: RCB_PS_16, chip_mode: RCB_CHIP_MASTER,
                              boot_dev: RCB_BOOT_16, drive: RCB_DRV_FULL,
                              addr_mode: RCB_PA_A23_21};
  wire rcb_cfg_t int_sel_cfg = int_cfg_use ? int_cfg : dflt_cfg;
  wire rcb_cfg_t cfg_nxt = rsel_flt_r ? pin_cfg : int_sel_cfg;
  wire rcb_dbg_port_t dbg_nxt = pin_flt_r[16] ? RCB_DBG_BDM : RCB_DBG_SCAN;

  // -------------------------------------------------------------
  // configuration capture
  // -------------------------------------------------------------
  rcb_cfg_t cfg_r; // latched chip settings
  rcb_dbg_port_t dbg_r; // latched debug port choice

  // tracks the selected settings and the debug pin while reset is held; the last value at release stays
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= cfg_nxt;
      dbg_r <= dbg_nxt;
    end
  end
  assign chip_cfg = cfg_r;
  assign debug_port = dbg_r;

  // -------------------------------------------------------------
  // chip select table
  // -------------------------------------------------------------
  logic [15:0] cs_base_r [`RCB_CS_COUNT]; // granule base per bank
  logic [15:0] cs_mask_r [`RCB_CS_COUNT]; // don't-care granule bits
  logic [`RCB_CS_COUNT-1:0] cs_valid_r; // bank enabled
  logic boot_global_r; // cs0 answers every address until programmed
  wire cs0_prog = cs_wr.en && (cs_wr.idx == 3'h0) && cs_wr.valid;

  // one bank written per cycle, addressed by index
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_valid_r <= '0;
      boot_global_r <= 1'b1;
      for (int i = 0; i < `RCB_CS_COUNT; i++) begin
        cs_base_r[i] <= `RCB_CS_BASE_RESET;
        cs_mask_r[i] <= `RCB_CS_MASK_RESET;
      end
    end else begin
      if (cs_wr.en) begin
        cs_base_r[cs_wr.idx] <= cs_wr.base;
        cs_mask_r[cs_wr.idx] <= cs_wr.mask;
        cs_valid_r[cs_wr.idx] <= cs_wr.valid;
      end
      if (cs0_prog) begin
        boot_global_r <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // chip select decode of the current read
  // -------------------------------------------------------------
  logic [`RCB_CS_COUNT-1:0] cs_match;
  for (genvar g = 0; g < `RCB_CS_COUNT; g++) begin : g_cs
    // a bank hits only while the read is on the bus
    assign cs_match[g] = rd_valid && cs_valid_r[g] && cs_hit(rd_addr, cs_base_r[g], cs_mask_r[g]);
  end
  // the global select lets the vector reads reach flash before setup
  wire boot_hit = cs_match[0] || (rd_valid && boot_global_r);
  assign boot_chip_select_n = ~boot_hit;
  assign ext_chip_select_n = ~cs_match[`RCB_CS_COUNT-1:1];

  // -------------------------------------------------------------
  // boot sequencer
  // -------------------------------------------------------------
  // the sequencer walks the three boot reads in a fixed order:
  // first the stack pointer word at address zero, then the
  // program counter word at address four, then the first
  // instruction at the loaded program counter
  // each read holds its request and address until the far side
  // answers with an acknowledge or an error pulse
  // an error answer on any of the three reads, or an odd program
  // counter, ends in the halted double-fault state
  // limitation: no bus timeout lives here; a silent flash keeps
  // the sequencer waiting, which the bus monitor must catch
  rcb_state_t st_r; // sequencer state
  rcb_state_t st_nxt;
  logic [31:0] addr_r; // read address
  logic [31:0] addr_nxt;
  logic [31:0] sp_r; // loaded stack pointer
  logic [31:0] pc_r; // loaded program counter
  wire rd_done = rd_ack || rd_err;
  wire pc_misalign = rd_data[0]; // odd pc is an address error

  // next state; any error before the first instruction halts
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    unique case (st_r)
      RCB_ST_WAIT_GNT: begin
        if (bus_grant) begin
          st_nxt = RCB_ST_RD_SP;
          addr_nxt = `RCB_SP_ADDR;
        end
      end
      RCB_ST_RD_SP: begin
        if (rd_err) begin
          st_nxt = RCB_ST_HALT;
        end else if (rd_ack) begin
          st_nxt = RCB_ST_RD_PC;
          addr_nxt = `RCB_PC_ADDR;
        end
      end
      RCB_ST_RD_PC: begin
        if (rd_err || (rd_ack && pc_misalign)) begin
          st_nxt = RCB_ST_HALT;
        end else if (rd_ack) begin
          st_nxt = RCB_ST_FETCH;
          addr_nxt = rd_data;
        end
      end
      RCB_ST_FETCH: begin
        if (rd_err) begin
          st_nxt = RCB_ST_HALT;
        end else if (rd_ack) begin
          st_nxt = RCB_ST_RUN;
        end
      end
      RCB_ST_RUN: begin
        st_nxt = RCB_ST_RUN;
      end
      RCB_ST_HALT: begin
        st_nxt = RCB_ST_HALT; // only reset leaves the double fault
      end
    endcase
  end

  // reset wins over any read in flight and is not resumed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= RCB_ST_WAIT_GNT;
      addr_r <= `RCB_SP_ADDR;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
    end
  end

  // vector loads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_r <= 32'h0000_0000;
      pc_r <= 32'h0000_0000;
    end else if (rd_ack && !rd_err) begin
      if (st_r == RCB_ST_RD_SP) begin
        sp_r <= rd_data;
      end
      if (st_r == RCB_ST_RD_PC) begin
        pc_r <= rd_data;
      end
    end
  end

  // -------------------------------------------------------------
  // core reset state
  // -------------------------------------------------------------
  // these registers only take their reset values; nothing in this
  // block writes them afterwards, so they hold until the next reset
  logic [15:0] sr_r; // status word
  logic [31:0] vbr_r; // vector base
  logic mem_en_r; // cache and local ram control enable

  // fixed after reset; software paths to change them live elsewhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sr_r <= `RCB_SR_RESET;
      vbr_r <= `RCB_VBR_RESET;
      mem_en_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  wire in_read = (st_r == RCB_ST_RD_SP) || (st_r == RCB_ST_RD_PC) || (st_r == RCB_ST_FETCH);
  assign bus_req = (st_r == RCB_ST_WAIT_GNT) || in_read;
  // the request stands for the whole read state; the state moves on
  // at the answer edge, so no extra qualification by rd_done is needed
  assign rd_valid = in_read;
  assign rd_addr = addr_r;
  assign core_status_word = sr_r;
  assign vector_base = vbr_r;
  assign cache_enable = mem_en_r;
  assign local_ram_enable = mem_en_r;
  assign stack_ptr = sp_r;
  assign prog_ctr = pc_r;
  assign core_running = (st_r == RCB_ST_RUN);
  assign core_halted = (st_r == RCB_ST_HALT);
endmodule
`default_nettype wire

// ===== rcb_reset_boot_monitor.sv
// Purpose: assertion checker for the reset configuration and boot block
// Assumes: sees top ports only; one clock domain
// Notes: bench leaves chip select programming idle, so the boot select stays global
`timescale 1ns/10ps
`default_nettype none
module rcb_reset_boot_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_req,
  input wire logic bus_grant,
  input wire logic rd_valid,
  input wire logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  input wire logic boot_chip_select_n,
  input wire logic [6:0] ext_chip_select_n,
  input wire rcb_pkg::rcb_cfg_t chip_cfg,
  input wire rcb_pkg::rcb_dbg_port_t debug_port,
  input wire logic [15:0] core_status_word,
  input wire logic [31:0] vector_base,
  input wire logic cache_enable,
  input wire logic local_ram_enable,
  input wire logic [31:0] prog_ctr,
  input wire logic core_running,
  input wire logic core_halted
);
  import rcb_pkg::*;
  // -------------------------------------------------------------
  // reset state and boot order
  // -------------------------------------------------------------
  // reset-state checks fire once, at the edge that releases reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_SR_RESET: assert property ($fell(sys_rst) |-> core_status_word == 16'h2700)
    else $error("status word wrong after reset");
  AST_VBR_ZERO: assert property ($fell(sys_rst) |-> vector_base == 32'h0)
    else $error("vector base not zero after reset");
  AST_MEM_OFF: assert property ($fell(sys_rst) |-> !cache_enable && !local_ram_enable)
    else $error("local memories enabled after reset");
  AST_ABORT: assert property ($fell(sys_rst) |-> !rd_valid && !core_running && !core_halted)
    else $error("activity survived reset");
  AST_SP_FIRST: assert property ($rose(rd_valid) |-> rd_addr == 32'h0 && bus_req)
    else $error("first boot read not at zero");
  AST_PC_NEXT: assert property (rd_valid && rd_ack && !rd_err && rd_addr == 32'h0 |=> rd_valid && rd_addr == 32'h4)
    else $error("second boot read not at four");
  AST_PC_LOAD: assert property (rd_valid && rd_ack && !rd_err && rd_addr == 32'h4 && !rd_data[0]
    |=> prog_ctr == $past(rd_data) && rd_addr == $past(rd_data))
    else $error("program counter not loaded from read");
  AST_ERR_HALT: assert property (rd_valid && rd_err |=> core_halted && !core_running && !rd_valid)
    else $error("error during boot did not halt");
  AST_GRANT: assert property (bus_req && !bus_grant && !rd_valid |=> !rd_valid)
    else $error("read started without grant");
  AST_BOOT_CS: assert property ((boot_chip_select_n == !rd_valid) && ext_chip_select_n == 7'h7f)
    else $error("boot select does not follow boot reads");
  AST_RUN_HOLD: assert property (core_running |=> core_running && !bus_req)
    else $error("running state not held");
  AST_CFG_HOLD: assert property (!$past(sys_rst) |-> $stable(chip_cfg) && $stable(debug_port))
    else $error("settings changed outside reset");
  cover property ($rose(core_running));
  cover property ($rose(core_halted));
  cover property (rd_valid && rd_ack && rd_addr == 32'h4);
endmodule
bind rcb_reset_boot rcb_reset_boot_monitor u_rcb_reset_boot_monitor (.*);
`default_nettype wire

// ===== rcb_flash_model.sv
// Purpose: boot flash partner answering the boot reads
// Assumes: answers only while the boot select is low
// Notes: data lines show a changing pattern outside the acknowledge cycle
`timescale 1ns/10ps
`default_nettype none
module rcb_flash_model (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [31:0] rd_addr,
  input wire logic boot_chip_select_n,
  input wire logic [1:0] wait_cyc,
  input wire logic [1:0] err_at,
  input wire logic [31:0] sp_word,
  input wire logic [31:0] pc_word,
  output logic rd_ack,
  output logic rd_err,
  output logic [31:0] rd_data
);
  // -------------------------------------------------------------
  // read responder
  // -------------------------------------------------------------
  logic [1:0] cnt_r;
  logic [1:0] idx_r; // reads answered in this boot; err_at 3 means none fails
  logic [31:0] word_r;
  logic [31:0] junk_r = 32'h5a5a_0f0f; // never the last word, so stale data is not mistaken
  wire sel = rd_valid && !boot_chip_select_n && !rd_ack && !rd_err;
  // one ack or error pulse after wait_cyc cycles of a selected read
  always_ff @(posedge clk) begin
    junk_r <= {junk_r[30:0], ~junk_r[31]};
    rd_ack <= 1'b0;
    rd_err <= 1'b0;
    if (!rd_valid) begin
      idx_r <= 2'h0;
      cnt_r <= 2'h0;
    end else if (sel && cnt_r == wait_cyc) begin
      rd_ack <= idx_r != err_at;
      rd_err <= idx_r == err_at;
      word_r <= rd_addr == 32'h0 ? sp_word : (rd_addr == 32'h4 ? pc_word : ~rd_addr);
      idx_r <= idx_r + 2'h1;
      cnt_r <= 2'h0;
    end else if (sel) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign rd_data = rd_ack ? word_r : junk_r;
endmodule
`default_nettype wire

// ===== rcb_reset_boot_tb.sv
// Purpose: self-checking bench for the reset configuration and boot block
// Assumes: switch on is logic one on the data pins
// Notes: clock mode has no documented default, so it is skipped in that case
`timescale 1ns/10ps
`default_nettype none
module rcb_reset_boot_tb;
  import rcb_pkg::*;
  // -------------------------------------------------------------
  // stimulus, model and checks
  // -------------------------------------------------------------
  logic clk = 1'b0, sys_rst = 1'b1, reset_config_select_n = 1'b1, debug_select_pin = 1'b0;
  logic int_cfg_use = 1'b0, bus_grant = 1'b0, rd_ack, rd_err, bus_req, rd_valid, boot_chip_select_n;
  logic core_running, core_halted, cache_enable, local_ram_enable;
  logic [15:0] data_pins_in = 16'h0, core_status_word;
  logic [31:0] rd_addr, rd_data, vector_base, stack_ptr, prog_ctr, sp_word = 32'h0, pc_word = 32'h0;
  logic [6:0] ext_chip_select_n;
  logic [1:0] wait_cyc = 2'h0, err_at = 2'h3;
  rcb_cfg_t int_cfg = '0, chip_cfg, ec;
  rcb_dbg_port_t debug_port;
  rcb_cs_wr_t cs_wr = '0; // bank programming left idle
  int err_total = 0, cmp_count = 0;
  logic [31:0] exp_q[$]; // expected boot read addresses in order
  always #12.5 clk = ~clk;
  rcb_reset_boot u_rcb_reset_boot (.*);
  rcb_flash_model u_rcb_flash_model (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // pin levels decoded as the switch tables describe
  function automatic rcb_cfg_t dec(input logic [15:0] p);
    dec.clk_mode = p[0] ? RCB_CLK_PLL : (p[1] ? RCB_CLK_EXT : RCB_CLK_ONE);
    dec.port_size = p[4:3] == 2'b01 ? RCB_PS_16 : (p[4:3] == 2'b10 ? RCB_PS_8 : RCB_PS_RSVD);
    dec.chip_mode = &p[7:5] ? RCB_CHIP_MASTER : RCB_CHIP_RSVD;
    dec.boot_dev = &p[9:8] ? RCB_BOOT_16 : (|p[9:8] ? RCB_BOOT_RSVD : RCB_BOOT_8);
    dec.drive = p[10] ? RCB_DRV_FULL : RCB_DRV_PART;
    dec.addr_mode = rcb_addr_mode_t'(~{p[11], p[12]});
  endfunction
  initial begin
    logic [15:0] p;
    logic done;
    int k;
    void'($urandom(32'h81da));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // even passes read the pins, odd ones the register or the defaults
    for (int i = 0; i < 16; i++) begin
      p = 16'($urandom);
      p = {p[15:13], 2'(i >> 1), p[10], 2'(i >> 2), i[2] ? 3'h7 : p[7:5], 2'(i >> 1), p[2], 2'(i >> 2)};
      @(posedge clk);
      sys_rst <= 1'b1;
      bus_grant <= 1'b0;
      reset_config_select_n <= i[0];
      int_cfg_use <= i[1];
      int_cfg <= dec(~p);
      data_pins_in <= p;
      debug_select_pin <= p[15];
      wait_cyc <= 2'(i);
      err_at <= (i < 3) ? 2'(i) : 2'h3;
      sp_word <= $urandom;
      pc_word <= {8'h10, 23'($urandom), i == 3};
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      ec = !i[0] ? dec(p) : (i[1] ? dec(~p) : '0);
      chk(32'(chip_cfg[7:0]), 32'(ec[7:0]));
      if (!(i[0] && !i[1])) chk(32'(chip_cfg[9:8]), 32'(ec[9:8]));
      chk(32'(debug_port), 32'(p[15]));
      chk(32'({rd_valid, core_running, core_halted}), 32'h0);
      chk(32'({cache_enable, local_ram_enable}), 32'h0);
      chk(32'(core_status_word), 32'h2700);
      chk(vector_base, 32'h0);
      exp_q = {32'h0, 32'h4, pc_word};
      done = 1'b0;
      for (k = 0; k < 80 && !done; k++) begin
        @(posedge clk);
        bus_grant <= k >= i % 3;
        data_pins_in <= ~p;
        debug_select_pin <= ~p[15];
        #1;
        if (rd_valid && (rd_ack || rd_err)) chk(rd_addr, exp_q.pop_front());
        done = core_running || core_halted || (i == 5 && k == 4);
      end
      if (!done) begin
        err_total++;
        close_out();
      end
      // pass five is cut short by the next reset in mid-boot
      if (i != 5) begin
        chk(32'({core_running, core_halted}), (err_at != 2'h3 || i == 3) ? 32'h1 : 32'h2);
        chk(32'(chip_cfg[7:0]), 32'(ec[7:0]));
        chk(32'(debug_port), 32'(p[15]));
        if (core_running) begin
          chk(stack_ptr, sp_word);
          chk(prog_ctr, pc_word);
          chk(32'(exp_q.size()), 32'h0);
        end
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
